// ### framing_pkg.sv
package framing_pkg;

  // ************************************************************
  // Register map (index; byte address is four times the index)
  // ************************************************************
  localparam int              ADDR_W          = 10;
  localparam int              DATA_W          = 32;
  localparam logic [7:0]      IDX_PAIR_B_MOD  = 8'h57;
  localparam logic [7:0]      IDX_RX_FRAMING  = 8'h58;
  localparam logic [7:0]      IDX_IRQ_STATUS  = 8'h60;
  localparam logic [7:0]      IDX_IRQ_ENABLE  = 8'h61;
  localparam logic [7:0]      IDX_IRQ_CLEAR   = 8'h62;
  localparam logic [7:0]      IDX_RX_STATUS   = 8'h63;
  localparam logic [7:0]      IDX_RX_CONFIG   = 8'h64;

  // ************************************************************
  // Field positions, write masks and reset values
  // ************************************************************
  localparam int              MOD_MILLER_BIT  = 6;
  localparam int              MOD_PULSE_LSB   = 4;
  localparam int              MOD_INV_BIT     = 3;
  localparam int              MOD_ENV_LSB     = 0;
  localparam int              RX_INVPAR_BIT   = 5;
  localparam int              RX_LEN_BIT      = 4;
  localparam int              RX_MSB_BIT      = 3;
  localparam int              RX_STOPBIT_BIT  = 2;
  localparam int              RX_PARODD_BIT   = 1;
  localparam int              CFG_PAR_EN_BIT  = 0;
  localparam logic [7:0]      MOD_WR_MASK     = 8'h7f;
  localparam logic [7:0]      RX_WR_MASK      = 8'h3e;
  localparam logic [7:0]      CFG_WR_MASK     = 8'h01;
  localparam logic [7:0]      MOD_RESET       = 8'h00;
  localparam logic [7:0]      RX_RESET        = 8'h00;
  localparam logic [7:0]      CFG_RESET       = 8'h01;

  // ************************************************************
  // Interrupt bits
  // ************************************************************
  localparam int              IRQ_W           = 4;
  localparam int              IRQ_BYTE        = 0;
  localparam int              IRQ_FRAME_END   = 1;
  localparam int              IRQ_FRAME_ERR   = 2;
  localparam int              IRQ_PARITY_ERR  = 3;

  // ************************************************************
  // Timing and character layout
  // ************************************************************
  localparam int              BIT_CYCLES      = 8;
  localparam int              DATA_BITS       = 8;
  localparam logic            STOP_BIT_VALUE  = 1'b1;

  // ************************************************************
  // Enumerations
  // ************************************************************
  typedef enum logic [2:0] {
    ENV_DIRECT    = 3'h0,
    ENV_MANCH     = 3'h1,
    ENV_MANCH_SUB = 3'h2,
    ENV_BPSK      = 3'h3,
    ENV_RZ_LATE   = 3'h4,
    ENV_RZ_EARLY  = 3'h5
  } env_e;

  typedef enum logic [1:0] {
    PULSE_NONE    = 2'h0,
    PULSE_START   = 2'h1,
    PULSE_HALF    = 2'h2,
    PULSE_QUARTER = 2'h3
  } pulse_e;

  typedef enum logic [1:0] {
    RX_IDLE   = 2'h0,
    RX_DATA   = 2'h1,
    RX_PARITY = 2'h2,
    RX_STOP   = 2'h3
  } rx_state_e;

endpackage

// ### pair_b_encoder.sv
`timescale 1ns/100ps
`default_nettype none
module pair_b_encoder
  import framing_pkg::*;
#(
  parameter int BIT_CYCLES_P = framing_pkg::BIT_CYCLES
)(
  // Clock and reset
  input  wire logic       mclk,
  input  wire logic       sys_rst,
  // Bit stream
  input  wire logic       bit_strobe,
  input  wire logic       bit_value,
  input  wire logic       pair_b_active,
  // Settings
  input  wire logic       miller_enable,
  input  wire logic [1:0] pulse_position,
  input  wire logic       invert,
  input  wire logic [2:0] envelope_select,
  // Modulator drive
  output logic            mod_out
);

  localparam int PH_W = $clog2(BIT_CYCLES_P);
  localparam int QLEN = BIT_CYCLES_P / 4;

  if (BIT_CYCLES_P < 4 || (BIT_CYCLES_P % 4) != 0)
  begin
    $error("BIT_CYCLES_P must be a multiple of 4, at least 4");
  end

  logic [PH_W-1:0] phase_q;
  logic            bit_q;
  logic            prev_q;
  logic            sub_q;
  logic            mod_q;

  // ************************************************************
  // Bit timing
  // ************************************************************
  wire [1:0] quarter   = 2'(32'(phase_q) / QLEN);
  wire       late_half = quarter[1];
  logic      env_bit;
  logic      window;

  always_comb
  begin
    case (env_e'(envelope_select))
      ENV_DIRECT    : env_bit = bit_q;
      ENV_MANCH     : env_bit = bit_q ^ late_half;
      ENV_MANCH_SUB : env_bit = (bit_q ^ late_half) & sub_q;
      ENV_BPSK      : env_bit = bit_q ^ sub_q;
      ENV_RZ_LATE   : env_bit = bit_q & late_half;
      ENV_RZ_EARLY  : env_bit = bit_q & ~late_half;
      default       : env_bit = 1'b0;
    endcase
  end

  // Miller: one pauses mid-bit, zero at start unless after a one
  wire miller_win = bit_q ? (quarter == 2'h2)
                          : (quarter == 2'h0) & ~prev_q;

  always_comb
  begin
    case (pulse_e'(pulse_position))
      PULSE_NONE    : window = 1'b1;
      PULSE_START   : window = (quarter == 2'h0);
      PULSE_HALF    : window = (quarter == 2'h2);
      PULSE_QUARTER : window = (quarter == 2'h3);
      default       : window = 1'b1;
    endcase
  end

  wire shaped  = miller_enable ? miller_win
                               : env_bit & window;
  wire coded   = shaped ^ invert;
  wire mod_d   = pair_b_active ? coded : bit_q;

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      phase_q <= '0;
      bit_q   <= 1'b0;
      prev_q  <= 1'b0;
      sub_q   <= 1'b0;
      mod_q   <= 1'b0;
    end
    else
    begin
      sub_q <= ~sub_q;
      mod_q <= mod_d;
      if (bit_strobe)
      begin
        phase_q <= '0;
        bit_q   <= bit_value;
        prev_q  <= bit_q;
      end
      else if (32'(phase_q) != BIT_CYCLES_P - 1)
        phase_q <= phase_q + 1'b1;
    end
  end

  assign mod_out = mod_q;

endmodule
`default_nettype wire

// ### symbol_framing_top.sv
// Chosen here: the Avalon-MM register port.
`timescale 1ns/100ps
`default_nettype none
module symbol_framing_top
  import framing_pkg::*;
#(
  parameter int BIT_CYCLES_P = framing_pkg::BIT_CYCLES
)(
  // Clock and reset
  input  wire logic                          mclk,
  input  wire logic                          sys_rst,
  // Avalon-MM slave
  input  wire logic [framing_pkg::ADDR_W-1:0] avs_address,
  input  wire logic                          avs_read,
  input  wire logic                          avs_write,
  input  wire logic [framing_pkg::DATA_W-1:0] avs_writedata,
  input  wire logic [3:0]                    avs_byteenable,
  output logic      [framing_pkg::DATA_W-1:0] avs_readdata,
  output logic                               avs_waitrequest,
  // Transmit bit stream
  input  wire logic                          tx_bit_strobe,
  input  wire logic                          tx_bit_value,
  input  wire logic                          tx_pair_b_active,
  output logic                               tx_mod_out,
  // Receive bit stream from demodulator
  input  wire logic                          rx_frame_start,
  input  wire logic                          rx_bit_valid,
  input  wire logic                          rx_bit_value,
  output logic                               demod_resync,
  // Receive byte stream to coprocessor
  output logic      [7:0]                    rx_byte_data,
  output logic                               rx_byte_valid,
  output logic                               rx_byte_parity_err,
  output logic                               rx_frame_done,
  output logic                               rx_frame_error,
  // Interrupt
  output logic                               irq
);

  // ************************************************************
  // Helper functions
  // ************************************************************
  function automatic logic [7:0] put_bit(input logic [7:0] b,
                                         input logic [2:0] pos,
                                         input logic       v);
    logic [7:0] r;
    r      = b;
    r[pos] = v;
    return r;
  endfunction

  function automatic logic hit(input logic [7:0] idx_w,
                               input logic [7:0] idx);
    return idx_w == idx;
  endfunction

  // ************************************************************
  // Register bus
  // ************************************************************
  logic              ack_q;
  logic [31:0]       rdata_q;
  logic [7:0]        mod_q;
  logic [7:0]        rxf_q;
  logic [7:0]        cfg_q;
  logic [IRQ_W-1:0]  ists_q;
  logic [IRQ_W-1:0]  ien_q;

  // One wait cycle: request taken at the second edge
  wire        req      = avs_read | avs_write;
  wire        take_bus = req & ack_q;
  wire [7:0]  idx      = avs_address[9:2];
  wire        aligned  = avs_address[1:0] == 2'h0;
  wire        lane0    = avs_byteenable[0];
  wire        wr_ok    = take_bus & avs_write & aligned & lane0;
  wire        wr_mod   = wr_ok & hit(idx, IDX_PAIR_B_MOD);
  wire        wr_rxf   = wr_ok & hit(idx, IDX_RX_FRAMING);
  wire        wr_cfg   = wr_ok & hit(idx, IDX_RX_CONFIG);
  wire        wr_ien   = wr_ok & hit(idx, IDX_IRQ_ENABLE);
  wire        wr_iclr  = wr_ok & hit(idx, IDX_IRQ_CLEAR);
  wire [7:0]  wbyte    = avs_writedata[7:0];

  assign avs_waitrequest = req & ~ack_q;

  // ************************************************************
  // Control fields
  // ************************************************************
  wire       miller_en    = mod_q[MOD_MILLER_BIT];
  wire [1:0] pulse_pos    = mod_q[MOD_PULSE_LSB +: 2];
  wire       pair_inv     = mod_q[MOD_INV_BIT];
  wire [2:0] env_sel      = mod_q[MOD_ENV_LSB +: 3];
  wire       halt_inv_par = rxf_q[RX_INVPAR_BIT];
  wire       halt_len     = rxf_q[RX_LEN_BIT];
  wire       msb_first    = rxf_q[RX_MSB_BIT];
  wire       stop_en      = rxf_q[RX_STOPBIT_BIT];
  wire       par_odd      = rxf_q[RX_PARODD_BIT];
  wire       par_en       = cfg_q[CFG_PAR_EN_BIT];

  // ************************************************************
  // Transmit encoder for the second symbol pair
  // ************************************************************
  pair_b_encoder #(
    .BIT_CYCLES_P    (BIT_CYCLES_P)
  ) u_enc (
    .mclk            (mclk),
    .sys_rst         (sys_rst),
    .bit_strobe      (tx_bit_strobe),
    .bit_value       (tx_bit_value),
    .pair_b_active   (tx_pair_b_active),
    .miller_enable   (miller_en),
    .pulse_position  (pulse_pos),
    .invert          (pair_inv),
    .envelope_select (env_sel),
    .mod_out         (tx_mod_out)
  );

  // ************************************************************
  // Receive framing
  // ************************************************************
  rx_state_e  state_q;
  rx_state_e  state_d;
  logic [2:0] bcnt_q;
  logic [7:0] shift_q;
  logic       xor_q;
  logic [7:0] len_q;
  logic       len_ok_q;
  logic [7:0] count_q;
  logic       perr_q;
  logic [7:0] byte_q;
  logic       bval_q;
  logic       bperr_q;
  logic       done_q;
  logic       ferr_q;
  logic       resync_q;

  wire        take      = rx_bit_valid & (state_q != RX_IDLE);
  wire        bit_in    = rx_bit_value;
  wire [2:0]  pos       = msb_first ? 3'h7 - bcnt_q : bcnt_q;
  wire        last_data = (state_q == RX_DATA) & (bcnt_q == 3'h7);
  wire [7:0]  byte_now  = (state_q == RX_DATA) ? put_bit(shift_q, pos, bit_in)
                                               : shift_q;
  wire        par_exp   = xor_q ^ par_odd;
  wire        par_ok    = bit_in == par_exp;
  wire        in_par    = take & (state_q == RX_PARITY);
  wire        in_stop   = take & (state_q == RX_STOP);
  wire        inv_stop  = in_par & ~par_ok & halt_inv_par;
  wire        stop_good = in_stop & (bit_in == STOP_BIT_VALUE);
  wire        stop_bad  = in_stop & (bit_in != STOP_BIT_VALUE);
  wire        char_done = (take & last_data & ~par_en & ~stop_en)
                        | (in_par & ~inv_stop & ~stop_en)
                        | stop_good;
  wire        perr_now  = in_par ? ~par_ok : perr_q;
  wire [7:0]  count_nx  = count_q + 8'h01;
  wire [7:0]  len_eff   = len_ok_q ? len_q : byte_now;
  wire        len_hit   = char_done & halt_len & (count_nx >= len_eff);
  wire        frame_end = inv_stop | len_hit;

  always_comb
  begin
    state_d = state_q;
    case (state_q)
      RX_IDLE   : state_d = RX_IDLE;
      RX_DATA   :
        if (take & last_data)
          state_d = par_en ? RX_PARITY : (stop_en ? RX_STOP : RX_DATA);
      RX_PARITY :
        if (take)
          state_d = stop_en ? RX_STOP : RX_DATA;
      RX_STOP   :
        if (take)
          state_d = RX_DATA;
      default   : state_d = RX_IDLE;
    endcase
    if (frame_end | stop_bad)
      state_d = RX_IDLE;
    if (rx_frame_start)
      state_d = RX_DATA;
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      state_q  <= RX_IDLE;
      bcnt_q   <= 3'h0;
      shift_q  <= 8'h00;
      xor_q    <= 1'b0;
      perr_q   <= 1'b0;
      len_q    <= 8'h00;
      len_ok_q <= 1'b0;
      count_q  <= 8'h00;
    end
    else
    begin
      state_q <= state_d;
      if (rx_frame_start)
      begin
        bcnt_q   <= 3'h0;
        xor_q    <= 1'b0;
        perr_q   <= 1'b0;
        len_ok_q <= 1'b0;
        count_q  <= 8'h00;
      end
      else if (take & (state_q == RX_DATA))
      begin
        shift_q <= byte_now;
        xor_q   <= xor_q ^ bit_in;
        bcnt_q  <= bcnt_q + 3'h1;
      end
      else if (in_par)
        perr_q <= ~par_ok;
      if (char_done & ~rx_frame_start)
      begin
        xor_q   <= 1'b0;
        perr_q  <= 1'b0;
        count_q <= count_nx;
        if (!len_ok_q)
        begin
          len_q    <= byte_now;
          len_ok_q <= 1'b1;
        end
      end
    end
  end

  // Outputs of the receive path are registered one cycle after the bit
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      byte_q   <= 8'h00;
      bval_q   <= 1'b0;
      bperr_q  <= 1'b0;
      done_q   <= 1'b0;
      ferr_q   <= 1'b0;
      resync_q <= 1'b0;
    end
    else
    begin
      bval_q   <= char_done & ~rx_frame_start;
      bperr_q  <= char_done ? perr_now & par_en : bperr_q;
      done_q   <= frame_end & ~rx_frame_start;
      ferr_q   <= stop_bad & ~rx_frame_start;
      resync_q <= stop_good;
      if (char_done)
        byte_q <= byte_now;
    end
  end

  assign rx_byte_data       = byte_q;
  assign rx_byte_valid      = bval_q;
  assign rx_byte_parity_err = bperr_q;
  assign rx_frame_done      = done_q;
  assign rx_frame_error     = ferr_q;
  assign demod_resync       = resync_q;

  // ************************************************************
  // Interrupt status
  // ************************************************************
  // A new event in the clear cycle survives: set is applied after clear
  logic [IRQ_W-1:0] ev;
  always_comb
  begin
    ev                 = '0;
    ev[IRQ_BYTE]       = bval_q;
    ev[IRQ_FRAME_END]  = done_q;
    ev[IRQ_FRAME_ERR]  = ferr_q;
    ev[IRQ_PARITY_ERR] = bval_q & bperr_q;
  end

  wire [IRQ_W-1:0] iclr = wr_iclr ? wbyte[IRQ_W-1:0] : '0;
  assign irq = |(ists_q & ien_q);

  // ************************************************************
  // Register storage and read mux
  // ************************************************************
  wire [7:0] rx_status = {3'h0, len_ok_q, 2'h0, state_q};
  logic [31:0] rmux;
  always_comb
  begin
    rmux = 32'h0000_0000;
    if (aligned)
    begin
      case (idx)
        IDX_PAIR_B_MOD : rmux[7:0]       = mod_q;
        IDX_RX_FRAMING : rmux[7:0]       = rxf_q;
        IDX_RX_CONFIG  : rmux[7:0]       = cfg_q;
        IDX_IRQ_STATUS : rmux[IRQ_W-1:0] = ists_q;
        IDX_IRQ_ENABLE : rmux[IRQ_W-1:0] = ien_q;
        IDX_RX_STATUS  : rmux            = {len_q, count_q, 8'h00,
                                            rx_status};
        default        : rmux            = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      ack_q   <= 1'b0;
      rdata_q <= 32'h0000_0000;
      mod_q   <= MOD_RESET;
      rxf_q   <= RX_RESET;
      cfg_q   <= CFG_RESET;
      ien_q   <= '0;
      ists_q  <= '0;
    end
    else
    begin
      ack_q  <= req & ~ack_q;
      ists_q <= (ists_q & ~iclr) | ev;
      if (req & ~ack_q & avs_read)
        rdata_q <= rmux;
      if (wr_mod)
        mod_q <= wbyte & MOD_WR_MASK;
      if (wr_rxf)
        rxf_q <= wbyte & RX_WR_MASK;
      if (wr_cfg)
        cfg_q <= wbyte & CFG_WR_MASK;
      if (wr_ien)
        ien_q <= wbyte[IRQ_W-1:0];
    end
  end

  assign avs_readdata = rdata_q;

endmodule
`default_nettype wire

// ### framing_checker.sv
`timescale 1ns/100ps
`default_nettype none
module framing_checker #(
  parameter int BIT_CYCLES_P = 8
)(
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // Register bus
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  // Transmit
  input wire logic tx_bit_strobe,
  input wire logic tx_bit_value,
  input wire logic tx_pair_b_active,
  input wire logic tx_mod_out,
  // Receive
  input wire logic rx_bit_valid,
  input wire logic rx_bit_value,
  input wire logic demod_resync,
  input wire logic rx_byte_valid,
  input wire logic rx_frame_done,
  input wire logic rx_frame_error
);
  // ********
  // Sequences
  // ********
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (sys_rst);

  sequence bus_wait_s;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  sequence bus_ack_s;
    (avs_read || avs_write) && !avs_waitrequest;
  endsequence
  // Eight quiet cycles: a new frame cannot deliver a byte sooner
  sequence rx_quiet_s;
    (!rx_byte_valid && !demod_resync) [*8];
  endsequence

  // ********
  // Assertions
  // ********
  chk_bus_wait: assert property (
    $rose(avs_read || avs_write) |-> bus_wait_s ##1 bus_ack_s)
    else $error("bus answer not after one wait cycle");
  chk_resync_byte: assert property (
    demod_resync |-> rx_byte_valid && !rx_frame_error)
    else $error("resync without a delivered byte");
  chk_stop_one: assert property (
    demod_resync |-> $past(rx_bit_valid) && $past(rx_bit_value))
    else $error("resync not caused by a one stop bit");
  chk_err_cause: assert property (
    rx_frame_error |-> $past(rx_bit_valid) && !$past(rx_bit_value)
      && !rx_byte_valid)
    else $error("frame error not caused by a zero stop bit");
  chk_err_abort: assert property (
    rx_frame_error |=> rx_quiet_s)
    else $error("reception went on after a frame error");
  chk_byte_cause: assert property (
    rx_byte_valid |-> $past(rx_bit_valid))
    else $error("byte delivered without a taken bit");
  chk_done_cause: assert property (
    rx_frame_done |-> $past(rx_bit_valid) && !rx_frame_error)
    else $error("frame end without a taken bit");
  chk_done_idle: assert property (
    rx_frame_done |=> rx_quiet_s)
    else $error("reception went on after frame end");
  chk_tx_raw: assert property (
    tx_bit_strobe && !tx_pair_b_active |->
      ##2 tx_mod_out == $past(tx_bit_value, 2))
    else $error("non pair output not the raw bit");
endmodule
`default_nettype wire

// ### card_model.sv
`timescale 1ns/100ps
`default_nettype none
module card_model (
  // Clock
  input  wire logic mclk,
  // Demodulated bit stream
  output var  logic frame_start,
  output var  logic bit_valid,
  output var  logic bit_value
);
  initial
  begin
    frame_start = 1'b0;
    bit_valid = 1'b0;
    bit_value = 1'b0;
  end

  task automatic start();
    @(posedge mclk);
    frame_start <= 1'b1;
    @(posedge mclk);
    frame_start <= 1'b0;
  endtask

  // Idle line shows the inverse of the last bit, never a stale copy
  task automatic put(input logic b, input int gap);
    @(posedge mclk);
    bit_valid <= 1'b1;
    bit_value <= b;
    @(posedge mclk);
    bit_valid <= 1'b0;
    bit_value <= ~b;
    repeat (gap) @(posedge mclk);
  endtask

  // Air order is always low bit first; the reader reorders
  task automatic send_char(input logic [7:0] dat, input logic par,
                           input logic stp, input logic hp,
                           input logic hs, input int gap);
    for (int i = 0; i < 8; i++)
      put(dat[i], gap);
    if (hp)
      put(par, gap);
    if (hs)
      put(stp, gap);
  endtask
endmodule
`default_nettype wire

// ### tb_tx_symbol_rx_bit_framing.sv
`timescale 1ns/100ps
`default_nettype none
module tb_tx_symbol_rx_bit_framing;
  import framing_pkg::*;
  logic        mclk, sys_rst, avs_read, avs_write, avs_waitrequest;
  logic        tx_bit_strobe, tx_bit_value, tx_pair_b_active, tx_mod_out;
  logic        rx_frame_start, rx_bit_valid, rx_bit_value, demod_resync;
  logic        rx_byte_valid, rx_byte_parity_err, rx_frame_done;
  logic        rx_frame_error, irq;
  logic [9:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata, rd, got_d;
  logic [3:0]  avs_byteenable, ps;
  logic [7:0]  rx_byte_data, cfg, dat, ed, ef, pat;
  logic [4:0]  fl;
  int          n_errors, checks_done, n_byte;
  // ********
  // Rows
  // ********
  // Write flag, index, write data, expected read
  logic [27:0] reg_rows [10] = '{28'h0_57_00_00, 28'h0_58_00_00,
    28'h0_64_00_01, 28'h0_60_00_00, 28'h1_57_ff_7f, 28'h1_58_ff_3e,
    28'h1_64_00_00, 28'h1_64_ff_01, 28'h1_70_ff_00, 28'h1_61_ff_0f};
  // Pair setting, {active, previous, bit}, pattern by phase
  logic [19:0] tx_rows [13] = '{
    20'h00_5_ff, 20'h08_5_00, 20'h04_5_f0,
    20'h05_5_0f, 20'h01_4_f0, 20'h06_5_00,
    20'h10_5_03, 20'h20_5_30, 20'h30_5_c0,
    20'h50_5_30, 20'h50_4_03, 20'h50_6_00,
    20'h08_1_ff};
  // Framing, byte, {parity, stop}, expected byte, expected flags
  logic [35:0] rx_rows [7] = '{
    36'h04_a5_1_a5_14, 36'h0c_1d_1_b8_14,
    36'h06_1d_1_1d_1c, 36'h06_1d_3_1d_14,
    36'h04_a5_0_00_01, 36'h24_a5_3_00_02,
    36'h00_3c_0_3c_10};

  symbol_framing_top #(.BIT_CYCLES_P(8)) symbol_framing_top_inst (
    .mclk(mclk), .sys_rst(sys_rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .tx_bit_strobe(tx_bit_strobe), .tx_bit_value(tx_bit_value),
    .tx_pair_b_active(tx_pair_b_active), .tx_mod_out(tx_mod_out),
    .rx_frame_start(rx_frame_start), .rx_bit_valid(rx_bit_valid),
    .rx_bit_value(rx_bit_value), .demod_resync(demod_resync),
    .rx_byte_data(rx_byte_data), .rx_byte_valid(rx_byte_valid),
    .rx_byte_parity_err(rx_byte_parity_err),
    .rx_frame_done(rx_frame_done), .rx_frame_error(rx_frame_error),
    .irq(irq));
  card_model card_model_inst (.mclk(mclk), .frame_start(rx_frame_start),
    .bit_valid(rx_bit_valid), .bit_value(rx_bit_value));

  always #20 mclk = ~mclk;

  always @(posedge mclk)
  begin
    if (rx_byte_valid)
    begin
      n_byte++;
      got_d = {24'h0, rx_byte_data};
    end
    fl = fl | {rx_byte_valid, rx_byte_valid & rx_byte_parity_err,
               demod_resync, rx_frame_done, rx_frame_error};
  end
  // ********
  // Tasks
  // ********
  task automatic check(input string nm, input logic [31:0] s,
                       input logic [31:0] e);
    checks_done++;
    if (s !== e)
    begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic bus(input logic wr, input logic [7:0] idx,
                     input logic [31:0] wd, output logic [31:0] q);
    int n;
    @(posedge mclk);
    avs_address <= {idx, 2'b00};
    avs_write <= wr;
    avs_read <= ~wr;
    avs_writedata <= wd;
    n = 0;
    do
    begin
      @(posedge mclk);
      n++;
    end
    while (avs_waitrequest !== 1'b0 && n < 20);
    if (n >= 20)
      n_errors++;
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic tx_bit(input logic b, output logic [7:0] p);
    @(posedge mclk);
    tx_bit_strobe <= 1'b1;
    tx_bit_value <= b;
    @(posedge mclk);
    tx_bit_strobe <= 1'b0;
    for (int i = 0; i < 8; i++)
    begin
      @(posedge mclk);
      #1 p[i] = tx_mod_out;
    end
  endtask

  task automatic rx_wait();
    repeat (3) @(posedge mclk);
    #1;
  endtask

  task finish_test();
    $display("checks_done=%0d n_errors=%0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // ********
  // Sequence
  // ********
  initial
  begin
    {mclk, avs_read, avs_write, tx_bit_strobe, tx_bit_value} = 5'h0;
    {avs_address, avs_writedata, fl, n_errors, checks_done} = '0;
    {tx_pair_b_active, n_byte} = '0;
    avs_byteenable = 4'hf;
    sys_rst = 1'b1;
    repeat (6) @(posedge mclk);
    sys_rst <= 1'b0;
    foreach (reg_rows[i])
    begin
      {ps, cfg, dat, ed} = reg_rows[i];
      if (ps[0])
        bus(1'b1, cfg, {24'h0, dat}, rd);
      bus(1'b0, cfg, 32'h0, rd);
      check("register", rd, {24'h0, ed});
    end
    foreach (tx_rows[i])
    begin
      {cfg, ps, ed} = tx_rows[i];
      bus(1'b1, 8'h57, {24'h0, cfg}, rd);
      tx_pair_b_active <= ps[2];
      tx_bit(ps[1], pat);
      tx_bit(ps[0], pat);
      check("tx shape", {24'h0, pat}, {24'h0, ed});
    end
    // Subcarrier forms: its phase is free, so shape and polarity are checked
    bus(1'b1, 8'h57, 32'h03, rd);
    tx_pair_b_active <= 1'b1;
    tx_bit(1'b0, ed);
    tx_bit(1'b1, pat);
    check("bpsk", {ed ^ pat, ed ^ {ed[6:0], ed[7]}}, 16'hffff);
    bus(1'b1, 8'h57, 32'h02, rd);
    tx_bit(1'b1, pat);
    check("sub", {pat[7:4], pat[3:0] ^ {pat[2:0], pat[3]}}, 8'h0f);
    foreach (rx_rows[i])
    begin
      {cfg, dat, ps, ed, ef} = rx_rows[i];
      bus(1'b1, 8'h58, {24'h0, cfg}, rd);
      #1 fl = '0;
      card_model_inst.start();
      card_model_inst.send_char(dat, ps[1], ps[0], 1'b1, cfg[2], i % 2);
      rx_wait();
      check("rx flags", {27'h0, fl}, {24'h0, ef});
      if (ef[4])
        check("rx byte", got_d, {24'h0, ed});
    end
    // Length halt: first byte is the length, itself counted
    bus(1'b1, 8'h58, 32'h14, rd);
    #1 fl = '0;
    n_byte = 0;
    card_model_inst.start();
    card_model_inst.send_char(8'h03, 1'b0, 1'b1, 1'b1, 1'b1, 0);
    card_model_inst.send_char(8'h11, 1'b0, 1'b1, 1'b1, 1'b1, 0);
    rx_wait();
    check("early end", {31'h0, fl[1]}, 32'h0);
    card_model_inst.send_char(8'h22, 1'b0, 1'b1, 1'b1, 1'b1, 0);
    rx_wait();
    check("length end", {31'h0, fl[1]}, 32'h1);
    card_model_inst.send_char(8'h44, 1'b0, 1'b1, 1'b1, 1'b1, 0);
    rx_wait();
    check("bytes", n_byte, 32'h3);
    check("last byte", got_d, 32'h22);
    // Interrupt masked, then enabled, then cleared
    bus(1'b1, 8'h61, 32'h0, rd);
    bus(1'b1, 8'h62, 32'hf, rd);
    bus(1'b1, 8'h58, 32'h04, rd);
    card_model_inst.start();
    card_model_inst.send_char(8'ha5, 1'b0, 1'b0, 1'b1, 1'b1, 0);
    rx_wait();
    check("irq masked", {31'h0, irq}, 32'h0);
    bus(1'b1, 8'h61, 32'h4, rd);
    #1 check("irq raised", {31'h0, irq}, 32'h1);
    bus(1'b0, 8'h60, 32'h0, rd);
    check("err status", rd & 32'h4, 32'h4);
    bus(1'b1, 8'h62, 32'h4, rd);
    #1 check("irq cleared", {31'h0, irq}, 32'h0);
    // Mid-run reset: framing control falls back to its reset value
    @(posedge mclk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge mclk);
    sys_rst <= 1'b0;
    bus(1'b0, 8'h58, 32'h0, rd);
    check("reset framing", rd, 32'h0);
    finish_test();
  end

  // Whole run is near 760 cycles
  initial
  begin
    repeat (8000) @(posedge mclk);
    n_errors++;
    finish_test();
  end
endmodule

bind symbol_framing_top framing_checker #(.BIT_CYCLES_P(BIT_CYCLES_P))
  framing_checker_inst (.mclk(mclk), .sys_rst(sys_rst),
  .avs_read(avs_read), .avs_write(avs_write),
  .avs_waitrequest(avs_waitrequest), .tx_bit_strobe(tx_bit_strobe),
  .tx_bit_value(tx_bit_value), .tx_pair_b_active(tx_pair_b_active),
  .tx_mod_out(tx_mod_out), .rx_bit_valid(rx_bit_valid),
  .rx_bit_value(rx_bit_value), .demod_resync(demod_resync),
  .rx_byte_valid(rx_byte_valid), .rx_frame_done(rx_frame_done),
  .rx_frame_error(rx_frame_error));
`default_nettype wire
